// [hdl/stq_timer_irq.sv]
// system timer interrupt mask, status, real-time counter and alarm with apb access
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module stq_timer_irq
  import stq_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [ADDR_W-1:0]      paddr,
  input  wire logic [DATA_W-1:0]      pwdata,
  input  wire logic                   periodEvtPin,
  input  wire logic                   watchdogOvfPin,
  input  wire logic                   rtTickPin,
  input  wire logic [OTHER_IRQ_W-1:0] otherPeriphIrq,
  output logic      [DATA_W-1:0]      prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        timerIrq,
  output logic                        systemIrq,
  output logic      [RT_W-1:0]        rtCount
);

  ////////////////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic regHit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] offset
  );
    regHit = (addr == offset);
  endfunction

  function automatic logic regMapped(
    input logic [ADDR_W-1:0] addr
  );
    regMapped = regHit(addr, OFF_STATUS)   || regHit(addr, OFF_IRQ_EN)   ||
                regHit(addr, OFF_IRQ_DIS)  || regHit(addr, OFF_IRQ_MASK) ||
                regHit(addr, OFF_ALARM)    || regHit(addr, OFF_CURRENT);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [PIN_EVT_N-1:0] pinIn;
  logic [PIN_EVT_N-1:0] pinRise;

  logic                 setupPhase;
  logic                 accessDone;
  logic                 wrDone;
  logic                 rdDone;

  logic [EVT_N-1:0]     mask_r;
  logic [EVT_N-1:0]     mask_nxt;
  logic [EVT_N-1:0]     status_r;
  logic [EVT_N-1:0]     status_nxt;
  logic [EVT_N-1:0]     statusClr;
  logic [EVT_N-1:0]     events;
  logic [EVT_N-1:0]     enBits;
  logic [EVT_N-1:0]     disBits;

  logic [RT_W-1:0]      alarm_r;
  logic [RT_W-1:0]      count_r;
  logic [RT_W-1:0]      countInc;
  logic                 rtIncrement;
  logic                 alarmMatch;

  logic [DATA_W-1:0]    prdata_r;
  logic [DATA_W-1:0]    readMux;
  logic                 pready_r;
  logic                 pslverr_r;
  logic                 timerIrq_r;
  logic                 systemIrq_r;

  ////////////////////////////////////////////////////////////////////////////////////////
  // event pins come from the slow clock side, so each is synchronised

  assign pinIn[BIT_PERIOD]   = periodEvtPin;
  assign pinIn[BIT_WATCHDOG] = watchdogOvfPin;
  assign pinIn[BIT_RT_INC]   = rtTickPin;

  genvar gi;
  generate
    for (gi = 0; gi < PIN_EVT_N; gi++) begin : g_pin
      stq_pin_sync u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .pinIn  (pinIn[gi]),
        .level  (),
        .rise   (pinRise[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////////////
  // apb phases

  // setup cycle: psel high, penable low; pready rises for the access cycle
  assign setupPhase = psel && !penable;
  assign accessDone = psel && penable && pready_r;
  assign wrDone     = accessDone && pwrite;
  assign rdDone     = accessDone && !pwrite;

  ////////////////////////////////////////////////////////////////////////////////////////
  // real-time counter

  assign rtIncrement = pinRise[BIT_RT_INC];
  // plain 20-bit add wraps to zero after the top value
  assign countInc    = count_r + RT_ONE;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_r <= RST_COUNT;
    end else if (rtIncrement) begin
      count_r <= countInc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // alarm value and compare

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      alarm_r <= RST_ALARM;
    end else if (wrDone && regHit(paddr, OFF_ALARM)) begin
      alarm_r <= pwdata[RT_W-1:0];
    end
  end

  // compare on the value being entered, so a match sets the flag once,
  // and zero is reached only after a full wrap of the counter
  assign alarmMatch = rtIncrement && (countInc == alarm_r);

  ////////////////////////////////////////////////////////////////////////////////////////
  // event vector in the shared layout

  assign events[BIT_PERIOD]   = pinRise[BIT_PERIOD];
  assign events[BIT_WATCHDOG] = pinRise[BIT_WATCHDOG];
  assign events[BIT_RT_INC]   = rtIncrement;
  assign events[BIT_ALARM]    = alarmMatch;

  ////////////////////////////////////////////////////////////////////////////////////////
  // mask register: set by enable writes, cleared by disable writes

  always_comb begin
    enBits  = '0;
    disBits = '0;
    if (wrDone && regHit(paddr, OFF_IRQ_EN)) begin
      enBits = pwdata[EVT_N-1:0];
    end
    if (wrDone && regHit(paddr, OFF_IRQ_DIS)) begin
      disBits = pwdata[EVT_N-1:0];
    end
    mask_nxt = (mask_r | enBits) & ~disBits;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_r <= RST_MASK;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // status flags

  // only bits that were returned by the read are cleared: an event arriving
  // after the data was captured, or in the clearing cycle, survives
  always_comb begin
    statusClr = '0;
    if (rdDone && regHit(paddr, OFF_STATUS)) begin
      statusClr = prdata_r[EVT_N-1:0];
    end
    status_nxt = (status_r & ~statusClr) | events;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_r <= RST_STATUS;
    end else begin
      status_r <= status_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // interrupt lines, taken from next values so they track the flags without lag

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timerIrq_r <= 1'b0;
    end else begin
      timerIrq_r <= |(status_nxt & mask_nxt);
    end
  end

  // other peripherals are on this clock already, no synchroniser
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      systemIrq_r <= 1'b0;
    end else begin
      systemIrq_r <= (|(status_nxt & mask_nxt)) || (|otherPeriphIrq);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // read data selection

  always_comb begin
    readMux = RST_RDATA;
    if (regHit(paddr, OFF_STATUS)) begin
      readMux[EVT_N-1:0] = status_r;
    end else if (regHit(paddr, OFF_IRQ_MASK)) begin
      readMux[EVT_N-1:0] = mask_r;
    end else if (regHit(paddr, OFF_ALARM)) begin
      readMux[RT_W-1:0] = alarm_r;
    end else if (regHit(paddr, OFF_CURRENT)) begin
      readMux[RT_W-1:0] = count_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // apb answer: data captured at setup, held through the access cycle

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_r <= RST_RDATA;
    end else if (setupPhase) begin
      prdata_r <= pwrite ? RST_RDATA : readMux;
    end
  end

  // one access cycle with no wait; dropped after it completes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= setupPhase;
    end
  end

  // unmapped addresses answer with an error and change nothing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pslverr_r <= 1'b0;
    end else if (setupPhase) begin
      pslverr_r <= !regMapped(paddr);
    end else if (accessDone) begin
      pslverr_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign timerIrq  = timerIrq_r;
  assign systemIrq = systemIrq_r;
  assign rtCount   = count_r;

endmodule

`default_nettype wire

// [hdl/stq_pkg.sv]
// constants of the system timer interrupt and real-time alarm block
//
// Operation
// - a one written to an enable register bit sets that mask bit, a zero leaves it alone.
// - a one written to a disable register bit clears that mask bit, a zero leaves it alone.
// - the mask register reads one for each enabled source and zero for each disabled one.
// - enable, disable and mask share bits 0 period, 1 watchdog, 2 increment, 3 alarm.
// - a 20-bit read/write alarm value is held and compared against the real-time counter.
// - an alarm value of zero gives the longest delay, the full 2^20 count span.
// - the current real-time register returns the 20-bit counter with zero above it.
// - one system interrupt output is the OR of all system peripheral requests.
// - each status flag sets on its event, holds, and a status read clears the flags.
// - the alarm flag sets when the real-time counter equals the alarm value.
// - the increment flag sets on each counter increment, and the counter wraps to zero.

package stq_pkg;

  ////////////////////////////////////////////////////////////////////////////////////////
  // bus shape
  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned DATA_W       = 32;

  ////////////////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [11:0] OFF_STATUS   = 12'h010;
  localparam logic [11:0] OFF_IRQ_EN   = 12'h014;
  localparam logic [11:0] OFF_IRQ_DIS  = 12'h018;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h01c;
  localparam logic [11:0] OFF_ALARM    = 12'h020;
  localparam logic [11:0] OFF_CURRENT  = 12'h024;

  ////////////////////////////////////////////////////////////////////////////////////////
  // shared event bit layout
  localparam int unsigned EVT_N        = 4;
  localparam int unsigned BIT_PERIOD   = 0;
  localparam int unsigned BIT_WATCHDOG = 1;
  localparam int unsigned BIT_RT_INC   = 2;
  localparam int unsigned BIT_ALARM    = 3;
  localparam int unsigned PIN_EVT_N    = 3;

  ////////////////////////////////////////////////////////////////////////////////////////
  // real-time counter and alarm
  localparam int unsigned RT_W         = 20;
  localparam logic [19:0] RT_ONE       = 20'h00001;

  ////////////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [3:0]  RST_MASK     = 4'h0;
  localparam logic [3:0]  RST_STATUS   = 4'h0;
  localparam logic [19:0] RST_ALARM    = 20'h00000;
  localparam logic [19:0] RST_COUNT    = 20'h00000;
  localparam logic [31:0] RST_RDATA    = 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////////////////
  // other system peripherals sharing the system line
  localparam int unsigned OTHER_IRQ_W  = 4;

endpackage

// [hdl/stq_pin_sync.sv]
// three-stage pin synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/1ps
`default_nettype none

module stq_pin_sync (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic pinIn,
  output logic      level,
  output logic      rise
);

  logic stage1_r;
  logic stage2_r;
  logic stage3_r;
  logic level_r;
  logic rise_r;

  ////////////////////////////////////////////////////////////////////////////////////////
  // stage one feeds stage two only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
      stage3_r <= 1'b0;
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // a change counts once stages two and three agree
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      level_r <= 1'b0;
      rise_r  <= 1'b0;
    end else begin
      if (stage2_r == stage3_r) begin
        level_r <= stage2_r;
      end
      rise_r <= (stage2_r == stage3_r) && stage2_r && !level_r;
    end
  end

  assign level = level_r;
  assign rise  = rise_r;

endmodule

`default_nettype wire

// [testbench/stq_timer_irq_monitor.sv]
// port assertions for the timer interrupt block
`timescale 1ns/1ps
`default_nettype none
module stq_timer_irq_monitor
  import stq_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   arst_n,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [ADDR_W-1:0]      paddr,
  input wire logic [DATA_W-1:0]      pwdata,
  input wire logic                   periodEvtPin,
  input wire logic                   watchdogOvfPin,
  input wire logic                   rtTickPin,
  input wire logic [OTHER_IRQ_W-1:0] otherPeriphIrq,
  input wire logic [DATA_W-1:0]      prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   timerIrq,
  input wire logic                   systemIrq,
  input wire logic [RT_W-1:0]        rtCount
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////
  sequence s_rd(logic [11:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  sequence s_acc;
    psel && penable && pready;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  a_ready_one: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one access cycle");
  a_mask_read: assert property (s_rd(OFF_IRQ_MASK) |=> prdata[31:4] == 28'h0)
    else $error("mask reserved bits not zero");
  a_err_low: assert property (psel && !penable && paddr < OFF_STATUS |=> pslverr)
    else $error("unmapped offset without error");
  a_alarm_read: assert property (s_rd(OFF_ALARM) |=> prdata[31:20] == 12'h0)
    else $error("alarm upper bits not zero");
  a_cur_read: assert property (s_rd(OFF_CURRENT) |=> prdata[31:20] == 12'h0
    && (prdata[19:0] == rtCount || prdata[19:0] == $past(rtCount)))
    else $error("current value read wrong");
  a_dis_all: assert property (s_acc and pwrite && paddr == OFF_IRQ_DIS
    && pwdata[3:0] == 4'hf |=> !timerIrq) else $error("irq after full disable");
  a_irq_fall: assert property ($fell(timerIrq) |-> $past(psel && penable))
    else $error("timer irq fell without access");
  a_sys_or: assert property (systemIrq == (timerIrq || $past(|otherPeriphIrq)))
    else $error("system irq not the or of requests");
  a_rt_step: assert property ($changed(rtCount) |-> rtCount == $past(rtCount) + RT_ONE)
    else $error("counter moved by other than one");
endmodule
bind stq_timer_irq stq_timer_irq_monitor u_mon (.clk(clk), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .periodEvtPin(periodEvtPin), .watchdogOvfPin(watchdogOvfPin), .rtTickPin(rtTickPin),
  .otherPeriphIrq(otherPeriphIrq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timerIrq(timerIrq), .systemIrq(systemIrq), .rtCount(rtCount));
`default_nettype wire

// [testbench/stq_evt_src.sv]
// event pin source standing in for the counters and prescaler
`timescale 1ns/1ps
`default_nettype none
module stq_evt_src (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [2:0] go,
  output logic      [2:0] pins
);
  logic [2:0] cnt_r [3];
  // high four clocks, low four more: every edge clears the synchroniser
  always_ff @(posedge clk or negedge arst_n) begin
    for (int i = 0; i < 3; i++) begin
      if (!arst_n) cnt_r[i] <= 3'h0;
      else if (cnt_r[i] != 3'h0) cnt_r[i] <= cnt_r[i] - 3'h1;
      else if (go[i]) cnt_r[i] <= 3'h7;
    end
  end
  always_comb begin
    for (int i = 0; i < 3; i++) pins[i] = cnt_r[i] > 3'h3;
  end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// self-checking bench for the timer interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import stq_pkg::*;
  logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdV;
  logic [3:0]  otherPeriphIrq = 4'h0;
  logic [2:0]  go = 3'h0, pins;
  logic        pready, pslverr, timerIrq, systemIrq, errV;
  logic [19:0] rtCount;
  int          n_errors = 0, total_checks = 0, seed = 32'h7dc9, r, mMask = 0, mStat = 0;
  int          mCnt = 0, mAlarm = 0;
  always #12.5 clk = ~clk;
  stq_timer_irq u_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .periodEvtPin(pins[0]),
    .watchdogOvfPin(pins[1]), .rtTickPin(pins[2]), .otherPeriphIrq(otherPeriphIrq),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timerIrq(timerIrq),
    .systemIrq(systemIrq), .rtCount(rtCount));
  stq_evt_src u_src (.clk(clk), .arst_n(arst_n), .go(go), .pins(pins));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] ex, got);
    total_checks++;
    if (got !== ex) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // request stands until pready is seen high at a rising edge; answer taken there
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk) penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdV = prdata;
    errV = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input int ex);
    apb(1'b0, a, 32'h0);
    chk(nm, ex, rdV);
  endtask
  task automatic evt(input int i);
    @(posedge clk) go <= 3'h1 << i;
    @(posedge clk) go <= 3'h0;
    repeat (16) @(posedge clk);
    mStat |= 1 << i;
    if (i == 2) begin
      mCnt = (mCnt + 1) % 1048576;
      if (mCnt == mAlarm) mStat |= 8;
    end
  endtask
  task automatic irqs;
    @(negedge clk);
    chk("timerIrq", 32'((mStat & mMask) != 0), {31'h0, timerIrq});
    chk("systemIrq", 32'((mStat & mMask) != 0 || otherPeriphIrq != 0), {31'h0, systemIrq});
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rdc("mask", OFF_IRQ_MASK, 0);
    rdc("alarm", OFF_ALARM, 0);
    rdc("current", OFF_CURRENT, 0);
    $display("test reset done");
    for (int k = 0; k < 12; k++) begin
      r = $random(seed);
      apb(1'b1, r[8] ? OFF_IRQ_EN : OFF_IRQ_DIS, r);
      mMask = r[8] ? (mMask | (r & 15)) : (mMask & ~r & 15);
      rdc("mask", OFF_IRQ_MASK, mMask);
    end
    $display("test mask done");
    apb(1'b1, OFF_IRQ_EN, 32'hf);
    apb(1'b1, OFF_IRQ_DIS, 32'h2);
    mMask = 13;
    for (int i = 0; i < 3; i++) begin
      evt(i);
      irqs;
      rdc("status", OFF_STATUS, mStat);
      mStat = 0;
      irqs;
      rdc("status", OFF_STATUS, 0);
    end
    evt(0);
    evt(1);
    rdc("status", OFF_STATUS, 3);
    mStat = 0;
    $display("test events done");
    mAlarm = mCnt + 2;
    apb(1'b1, OFF_ALARM, 32'hfff00000 | mAlarm);
    rdc("alarm", OFF_ALARM, mAlarm);
    evt(2);
    evt(2);
    irqs;
    rdc("status", OFF_STATUS, mStat);
    mStat = 0;
    apb(1'b1, OFF_CURRENT, 32'hfffff);
    rdc("current", OFF_CURRENT, mCnt);
    chk("rtCount", mCnt, {12'h0, rtCount});
    $display("test alarm done");
    r = $random(seed);
    @(posedge clk) otherPeriphIrq <= r[3:0] | 4'h1;
    repeat (2) @(posedge clk);
    irqs;
    @(posedge clk) otherPeriphIrq <= 4'h0;
    repeat (2) @(posedge clk);
    irqs;
    apb(1'b1, 12'h004, 32'hf);
    chk("pslverr", 1, {31'h0, errV});
    rdc("mask", OFF_IRQ_MASK, mMask);
    rdc("unmapped", 12'h008, 0);
    chk("pslverr", 1, {31'h0, errV});
    rdc("enable", OFF_IRQ_EN, 0);
    chk("pslverr", 0, {31'h0, errV});
    rdc("disable", OFF_IRQ_DIS, 0);
    apb(1'b1, OFF_STATUS, 32'hf);
    rdc("status", OFF_STATUS, 0);
    apb(1'b1, OFF_IRQ_DIS, 32'hf);
    mMask = 0;
    rdc("mask", OFF_IRQ_MASK, 0);
    $display("test refusals done");
    close_out;
  end
  // whole run needs about 300 clocks
  initial begin
    #(25 * 8000);
    n_errors++;
    close_out;
  end
endmodule
`default_nettype wire
